// ==== hdl/npcb_defines.svh ====
// register offsets, field positions and reset values of the preset/binding bank
`ifndef NPCB_DEFINES_SVH
`define NPCB_DEFINES_SVH

`define NPCB_ADDR_W           12
`define NPCB_DATA_W           16

`define NPCB_OFF_DEV_CTRL     12'h200
`define NPCB_OFF_STATUS       12'h201
`define NPCB_OFF_SRC_MODE     12'h214
`define NPCB_OFF_PRESET_SEL   12'h215
`define NPCB_OFF_BINDING      12'h216
`define NPCB_OFF_REF_DIV      12'h217
`define NPCB_OFF_PHASE_ALIGN  12'h219

`define NPCB_RST_DEV_CTRL     5'h00
`define NPCB_RST_SRC_MODE     2'h0
`define NPCB_RST_SEL          2'h0
`define NPCB_RST_BINDING      2'h2
`define NPCB_RST_REF_DIV      16'h0000
`define NPCB_RST_PHASE_ALIGN  2'h2

`define NPCB_DIV_RECOMMENDED  16'h2000

// device control fields
`define NPCB_CTL_SINGLE       0
`define NPCB_CTL_LINK_EN      1
`define NPCB_CTL_CAL_EN       2
`define NPCB_CTL_PD_A         3
`define NPCB_CTL_PD_B         4
// status fields
`define NPCB_ST_BIND_ERR      5
`define NPCB_ST_UNSAFE_BIND   6
`define NPCB_ST_DIV_HIGH      7
// preset select / binding / phase alignment fields
`define NPCB_SEL_A_LSB        0
`define NPCB_SEL_B_LSB        2
`define NPCB_BIND_A           0
`define NPCB_BIND_B           1
`define NPCB_ALIGN_NEXT       0
`define NPCB_ALIGN_LINK       1

`endif

// ==== hdl/npcb_pkg.sv ====
// types shared by the preset/binding bank
package npcb_pkg;

  typedef enum logic [1:0] {
    NPCB_SRC_REGISTER,
    NPCB_SRC_PINS_SPLIT,
    NPCB_SRC_PINS_SHARED,
    NPCB_SRC_RESERVED
  } npcb_src_mode_t;

  typedef logic [1:0] npcb_preset_t;

endpackage

// ==== hdl/npcb_pin_sync.sv ====
// three-stage synchroniser for asynchronous pin groups
`timescale 1ns/10ps
module npcb_pin_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_resetn,
  // pin side and settled value
  input  wire logic [WIDTH-1:0] i_pins,
  output logic      [WIDTH-1:0] o_stable
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // a zero-width group cannot carry a preset index
  if (WIDTH < 1) begin : g_bad_width
    $error("npcb_pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge i_core_clk) begin
    meta_q <= i_pins;
    s2_q   <= meta_q;
    s3_q   <= s2_q;
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_stable <= '0;
    end else if (s2_q == s3_q) begin
      o_stable <= s3_q;
    end
  end

endmodule

// ==== hdl/npcb_preset_resolve.sv ====
// resolves the active preset index of both down-converters
`timescale 1ns/10ps
module npcb_preset_resolve (
  // configuration
  input  wire npcb_pkg::npcb_src_mode_t i_src_mode,
  input  wire logic                     i_single_channel,
  input  wire npcb_pkg::npcb_preset_t   i_sel_a,
  input  wire npcb_pkg::npcb_preset_t   i_sel_b,
  // settled preset pins
  input  wire npcb_pkg::npcb_preset_t   i_pins_a,
  input  wire npcb_pkg::npcb_preset_t   i_pins_b,
  // resolved indices
  output npcb_pkg::npcb_preset_t        o_preset_a,
  output npcb_pkg::npcb_preset_t        o_preset_b
);

  npcb_pkg::npcb_preset_t dual_b;

  always_comb begin
    case (i_src_mode)
      npcb_pkg::NPCB_SRC_REGISTER: begin
        o_preset_a = i_sel_a;
        dual_b     = i_sel_b;
      end
      npcb_pkg::NPCB_SRC_PINS_SPLIT: begin
        o_preset_a = i_pins_a;
        dual_b     = i_pins_b;
      end
      npcb_pkg::NPCB_SRC_PINS_SHARED: begin
        o_preset_a = i_pins_a;
        dual_b     = i_pins_a;
      end
      // reserved code falls back to register control
      default: begin
        o_preset_a = i_sel_a;
        dual_b     = i_sel_b;
      end
    endcase
    // single down-converter follows channel A's method only
    o_preset_b = i_single_channel ? o_preset_a : dual_b;
  end

endmodule

// ==== hdl/npcb_top.sv ====
// register bank for NCO preset selection, channel binding and reference divisor
`timescale 1ns/10ps
`include "npcb_defines.svh"
module npcb_top #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_resetn,
  // register port
  input  wire logic [`NPCB_ADDR_W-1:0]  i_addr,
  input  wire logic [`NPCB_DATA_W-1:0]  i_wr_data,
  input  wire logic                     i_wr_en,
  input  wire logic                     i_rd_en,
  output logic      [`NPCB_DATA_W-1:0]  o_rd_data,
  // preset select pins
  input  wire logic [1:0]               i_preset_pins_a,
  input  wire logic [1:0]               i_preset_pins_b,
  // active presets
  output logic      [1:0]               o_active_preset_a,
  output logic      [1:0]               o_active_preset_b,
  // channel routing
  output logic                          o_dig_a_from_conv_b,
  output logic                          o_dig_b_from_conv_b,
  // power-down controls
  output logic                          o_converter_a_power_down,
  output logic                          o_converter_b_power_down,
  output logic                          o_dig_a_power_down,
  output logic                          o_dig_b_power_down,
  output logic                          o_link_a_power_down,
  output logic                          o_link_b_power_down,
  // mode controls
  output logic                          o_single_channel_mode,
  output logic                          o_serial_link_enable,
  output logic                          o_cal_enable,
  // reference divisor
  output logic      [DIV_W-1:0]         o_reference_divisor,
  output logic                          o_divisor_enable,
  // phase alignment
  output logic                          o_phase_align_on_link,
  output logic                          o_phase_align_arm
);

  // only the 16-bit divisor register exists; other widths have no decode
  if (DIV_W != 16) begin : g_bad_div_w
    $error("npcb_top: DIV_W must be 16");
  end

  // exact offset match, so unmapped offsets never alias a register
  function automatic logic hit(input logic [`NPCB_ADDR_W-1:0] addr,
                               input logic [`NPCB_ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  // power-down of the converter that one binding bit selects
  function automatic logic bound_pd(input logic       from_b,
                                    input logic [4:0] ctrl);
    bound_pd = from_b ? ctrl[`NPCB_CTL_PD_B] : ctrl[`NPCB_CTL_PD_A];
  endfunction

  // register state
  logic [4:0]                 dev_ctrl_q;
  npcb_pkg::npcb_src_mode_t   src_mode_q;
  npcb_pkg::npcb_preset_t     sel_a_q;
  npcb_pkg::npcb_preset_t     sel_b_q;
  logic [1:0]                 binding_q;
  logic [DIV_W-1:0]           ref_div_q;
  logic                       align_link_q;
  logic                       align_next_q;
  logic                       unsafe_bind_q;

  // phase alignment reset word, split into its two fields
  localparam logic [1:0]      ALIGN_RST = `NPCB_RST_PHASE_ALIGN;

  // resolved presets
  npcb_pkg::npcb_preset_t     pins_a;
  npcb_pkg::npcb_preset_t     pins_b;
  npcb_pkg::npcb_preset_t     preset_a_d;
  npcb_pkg::npcb_preset_t     preset_b_d;

  // write decode
  logic                       wr_ctrl;
  logic                       wr_status;
  logic                       wr_mode;
  logic                       wr_sel;
  logic                       wr_bind;
  logic                       wr_div;
  logic                       wr_align;

  // derived conditions
  logic                       single_mode;
  logic                       bind_err;
  logic                       div_high;
  logic                       dig_a_pd_d;
  logic                       dig_b_pd_d;
  logic [`NPCB_DATA_W-1:0]    rd_data_d;
  logic [`NPCB_DATA_W-1:0]    status_word;

  assign wr_ctrl   = i_wr_en && hit(i_addr, `NPCB_OFF_DEV_CTRL);
  assign wr_status = i_wr_en && hit(i_addr, `NPCB_OFF_STATUS);
  assign wr_mode   = i_wr_en && hit(i_addr, `NPCB_OFF_SRC_MODE);
  assign wr_sel    = i_wr_en && hit(i_addr, `NPCB_OFF_PRESET_SEL);
  assign wr_bind   = i_wr_en && hit(i_addr, `NPCB_OFF_BINDING);
  assign wr_div    = i_wr_en && hit(i_addr, `NPCB_OFF_REF_DIV);
  assign wr_align  = i_wr_en && hit(i_addr, `NPCB_OFF_PHASE_ALIGN);

  assign single_mode = dev_ctrl_q[`NPCB_CTL_SINGLE];

  // pins come from outside the clock domain
  npcb_pin_sync #(
    .WIDTH (2)
  ) u_sync_a (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_pins     (i_preset_pins_a),
    .o_stable   (pins_a)
  );

  npcb_pin_sync #(
    .WIDTH (2)
  ) u_sync_b (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_pins     (i_preset_pins_b),
    .o_stable   (pins_b)
  );

  npcb_preset_resolve u_resolve (
    .i_src_mode       (src_mode_q),
    .i_single_channel (single_mode),
    .i_sel_a          (sel_a_q),
    .i_sel_b          (sel_b_q),
    .i_pins_a         (pins_a),
    .i_pins_b         (pins_b),
    .o_preset_a       (preset_a_d),
    .o_preset_b       (preset_b_d)
  );

  // device control: mode, link, calibration, converter power-down
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      dev_ctrl_q <= `NPCB_RST_DEV_CTRL;
    end else if (wr_ctrl) begin
      dev_ctrl_q <= i_wr_data[4:0];
    end
  end

  // preset source mode
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      src_mode_q <= npcb_pkg::npcb_src_mode_t'(`NPCB_RST_SRC_MODE);
    end else if (wr_mode) begin
      src_mode_q <= npcb_pkg::npcb_src_mode_t'(i_wr_data[1:0]);
    end
  end

  // preset select fields
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      sel_a_q <= `NPCB_RST_SEL;
      sel_b_q <= `NPCB_RST_SEL;
    end else if (wr_sel) begin
      sel_a_q <= i_wr_data[`NPCB_SEL_A_LSB +: 2];
      sel_b_q <= i_wr_data[`NPCB_SEL_B_LSB +: 2];
    end
  end

  // channel binding; the device does not block an unsafe rewrite
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      binding_q <= `NPCB_RST_BINDING;
    end else if (wr_bind) begin
      binding_q <= i_wr_data[1:0];
    end
  end

  // a rebind with link or calibration still enabled is flagged, not refused
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      unsafe_bind_q <= 1'b0;
    end else if (wr_bind &&
                 (dev_ctrl_q[`NPCB_CTL_LINK_EN] || dev_ctrl_q[`NPCB_CTL_CAL_EN])) begin
      unsafe_bind_q <= 1'b1;
    end else if (wr_status && i_wr_data[`NPCB_ST_UNSAFE_BIND]) begin
      unsafe_bind_q <= 1'b0;
    end
  end

  // reference divisor, one value for every preset of both channels
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ref_div_q <= `NPCB_RST_REF_DIV;
    end else if (wr_div) begin
      ref_div_q <= i_wr_data[DIV_W-1:0];
    end
  end

  // phase alignment control
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      align_link_q <= ALIGN_RST[`NPCB_ALIGN_LINK];
      align_next_q <= ALIGN_RST[`NPCB_ALIGN_NEXT];
    end else if (wr_align) begin
      align_link_q <= i_wr_data[`NPCB_ALIGN_LINK];
      align_next_q <= i_wr_data[`NPCB_ALIGN_NEXT];
    end
  end

  // arming needs a 0 then a 1; rewriting 1 over 1 does not re-arm
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_phase_align_arm <= 1'b0;
    end else begin
      o_phase_align_arm <= wr_align && i_wr_data[`NPCB_ALIGN_NEXT] && !align_next_q;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_phase_align_on_link <= ALIGN_RST[`NPCB_ALIGN_LINK];
    end else begin
      o_phase_align_on_link <= align_link_q;
    end
  end

  // registered preset indices so the NCO muxes switch on a clock edge
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_active_preset_a <= 2'h0;
      o_active_preset_b <= 2'h0;
    end else begin
      o_active_preset_a <= preset_a_d;
      o_active_preset_b <= preset_b_d;
    end
  end

  // routing follows the binding bits
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_dig_a_from_conv_b <= 1'b0;
      o_dig_b_from_conv_b <= 1'b1;
    end else begin
      o_dig_a_from_conv_b <= binding_q[`NPCB_BIND_A];
      o_dig_b_from_conv_b <= binding_q[`NPCB_BIND_B];
    end
  end

  // each digital channel sleeps with the converter it is bound to
  assign dig_a_pd_d = bound_pd(binding_q[`NPCB_BIND_A], dev_ctrl_q);
  assign dig_b_pd_d = bound_pd(binding_q[`NPCB_BIND_B], dev_ctrl_q);

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_dig_a_power_down  <= 1'b0;
      o_dig_b_power_down  <= 1'b0;
      o_link_a_power_down <= 1'b0;
      o_link_b_power_down <= 1'b0;
    end else begin
      o_dig_a_power_down  <= dig_a_pd_d;
      o_dig_b_power_down  <= dig_b_pd_d;
      o_link_a_power_down <= dig_a_pd_d;
      o_link_b_power_down <= dig_b_pd_d;
    end
  end

  // mode outputs and converter power-downs
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_single_channel_mode    <= 1'b0;
      o_serial_link_enable     <= 1'b0;
      o_cal_enable             <= 1'b0;
      o_converter_a_power_down <= 1'b0;
      o_converter_b_power_down <= 1'b0;
    end else begin
      o_single_channel_mode    <= dev_ctrl_q[`NPCB_CTL_SINGLE];
      o_serial_link_enable     <= dev_ctrl_q[`NPCB_CTL_LINK_EN];
      o_cal_enable             <= dev_ctrl_q[`NPCB_CTL_CAL_EN];
      o_converter_a_power_down <= dev_ctrl_q[`NPCB_CTL_PD_A];
      o_converter_b_power_down <= dev_ctrl_q[`NPCB_CTL_PD_B];
    end
  end

  // zero divisor leaves the NCO a plain 32-bit accumulator
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_reference_divisor <= `NPCB_RST_REF_DIV;
      o_divisor_enable    <= 1'b0;
    end else begin
      o_reference_divisor <= ref_div_q;
      o_divisor_enable    <= (ref_div_q != '0);
    end
  end

  // software-side misuse is reported only; the hardware cannot repair it
  assign bind_err = single_mode && (binding_q != `NPCB_RST_BINDING);
  assign div_high = (ref_div_q > `NPCB_DIV_RECOMMENDED);

  // status bits 0-4, 8 and 9 show registered outputs and lag a write by two edges; bits 5-7 come from register state and lag by one
  always_comb begin
    status_word = '0;
    status_word[1:0] = o_active_preset_a;
    status_word[3:2] = o_active_preset_b;
    status_word[4]   = o_divisor_enable;
    status_word[`NPCB_ST_BIND_ERR]    = bind_err;
    status_word[`NPCB_ST_UNSAFE_BIND] = unsafe_bind_q;
    status_word[`NPCB_ST_DIV_HIGH]    = div_high;
    status_word[8]   = o_dig_a_power_down;
    status_word[9]   = o_dig_b_power_down;
  end

  // read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    rd_data_d = '0;
    case (i_addr)
      `NPCB_OFF_DEV_CTRL:    rd_data_d[4:0] = dev_ctrl_q;
      `NPCB_OFF_STATUS:      rd_data_d = status_word;
      `NPCB_OFF_SRC_MODE:    rd_data_d[1:0] = src_mode_q;
      `NPCB_OFF_PRESET_SEL: begin
        rd_data_d[`NPCB_SEL_A_LSB +: 2] = sel_a_q;
        rd_data_d[`NPCB_SEL_B_LSB +: 2] = sel_b_q;
      end
      `NPCB_OFF_BINDING:     rd_data_d[1:0] = binding_q;
      `NPCB_OFF_REF_DIV:     rd_data_d[DIV_W-1:0] = ref_div_q;
      `NPCB_OFF_PHASE_ALIGN: begin
        rd_data_d[`NPCB_ALIGN_LINK] = align_link_q;
        rd_data_d[`NPCB_ALIGN_NEXT] = align_next_q;
      end
      default:               rd_data_d = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_rd_data <= '0;
    end else if (i_rd_en) begin
      o_rd_data <= rd_data_d;
    end else begin
      o_rd_data <= '0;
    end
  end

endmodule

// ==== sim/npcb_top_monitor.sv ====
// concurrent checks on the ports of the preset/binding register bank
`timescale 1ns/10ps
`include "npcb_defines.svh"
module npcb_top_monitor #(
  parameter int DIV_W = 16
) (
  // clock, reset and register port
  input wire logic                    i_core_clk,
  input wire logic                    i_resetn,
  input wire logic [`NPCB_ADDR_W-1:0] i_addr,
  input wire logic [`NPCB_DATA_W-1:0] i_wr_data,
  input wire logic                    i_wr_en,
  input wire logic                    i_rd_en,
  input wire logic [`NPCB_DATA_W-1:0] o_rd_data,
  // design outputs
  input wire logic [1:0]              o_active_preset_a,
  input wire logic [1:0]              o_active_preset_b,
  input wire logic                    o_dig_a_from_conv_b,
  input wire logic                    o_dig_b_from_conv_b,
  input wire logic                    o_converter_a_power_down,
  input wire logic                    o_converter_b_power_down,
  input wire logic                    o_dig_a_power_down,
  input wire logic                    o_dig_b_power_down,
  input wire logic                    o_link_a_power_down,
  input wire logic                    o_link_b_power_down,
  input wire logic                    o_single_channel_mode,
  input wire logic [DIV_W-1:0]        o_reference_divisor,
  input wire logic                    o_divisor_enable
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_div_wr;
    i_wr_en && i_addr == 12'h217;
  endsequence
  sequence s_bind_wr;
    i_wr_en && i_addr == 12'h216;
  endsequence

  a_div_write:
    assert property (s_div_wr |-> ##2 o_reference_divisor == $past(i_wr_data, 2))
    else $error("divisor output does not follow its write");
  a_bind_write:
    assert property (s_bind_wr |-> ##2
      {o_dig_b_from_conv_b, o_dig_a_from_conv_b} == $past(i_wr_data[1:0], 2))
    else $error("routing does not follow the binding write");
  a_reset_values:
    assert property (disable iff (1'b0) !i_resetn |=> o_dig_b_from_conv_b
      && !o_dig_a_from_conv_b && o_reference_divisor == '0 && !o_divisor_enable)
    else $error("wrong reset value on routing or divisor");
  a_dig_a_pd:
    assert property (o_dig_a_power_down == (o_dig_a_from_conv_b ?
      o_converter_b_power_down : o_converter_a_power_down))
    else $error("digital A power-down not tied to its bound converter");
  a_dig_b_pd:
    assert property (o_dig_b_power_down == (o_dig_b_from_conv_b ?
      o_converter_b_power_down : o_converter_a_power_down))
    else $error("digital B power-down not tied to its bound converter");
  a_link_pd_follow:
    assert property (o_link_a_power_down == o_dig_a_power_down
      && o_link_b_power_down == o_dig_b_power_down)
    else $error("link power-down differs from its digital channel");
  a_div_enable:
    assert property (o_divisor_enable == (o_reference_divisor != '0))
    else $error("divisor enable wrong for divisor value");
  a_single_copy:
    assert property (o_single_channel_mode |-> o_active_preset_b == o_active_preset_a)
    else $error("single mode preset B differs from preset A");
  a_rd_idle:
    assert property (!$past(i_rd_en) |-> o_rd_data == 16'h0000)
    else $error("read data outside its read cycle");
endmodule

bind npcb_top npcb_top_monitor #(.DIV_W(DIV_W)) u_monitor (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
  .o_active_preset_a(o_active_preset_a), .o_active_preset_b(o_active_preset_b),
  .o_dig_a_from_conv_b(o_dig_a_from_conv_b), .o_dig_b_from_conv_b(o_dig_b_from_conv_b),
  .o_converter_a_power_down(o_converter_a_power_down),
  .o_converter_b_power_down(o_converter_b_power_down),
  .o_dig_a_power_down(o_dig_a_power_down), .o_dig_b_power_down(o_dig_b_power_down),
  .o_link_a_power_down(o_link_a_power_down), .o_link_b_power_down(o_link_b_power_down),
  .o_single_channel_mode(o_single_channel_mode),
  .o_reference_divisor(o_reference_divisor), .o_divisor_enable(o_divisor_enable));

// ==== sim/npcb_top_tb.sv ====
// self-checking bench for the preset/binding register bank
`timescale 1ns/10ps
module npcb_top_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [1:0]  pins_a = 2'h0;
  logic [1:0]  pins_b = 2'h0;
  logic [15:0] rdata, divisor;
  logic [1:0]  act_a, act_b;
  logic        rt_a, rt_b, cpd_a, cpd_b, dpd_a, dpd_b, lpd_a, lpd_b, div_en;
  logic        sgl, link_en, cal_en, al_link, al_arm;
  int          fails = 0;
  int          samples_checked = 0;

  npcb_top u_dut (
    .i_core_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rdata),
    .i_preset_pins_a(pins_a), .i_preset_pins_b(pins_b),
    .o_active_preset_a(act_a), .o_active_preset_b(act_b),
    .o_dig_a_from_conv_b(rt_a), .o_dig_b_from_conv_b(rt_b),
    .o_converter_a_power_down(cpd_a), .o_converter_b_power_down(cpd_b),
    .o_dig_a_power_down(dpd_a), .o_dig_b_power_down(dpd_b),
    .o_link_a_power_down(lpd_a), .o_link_b_power_down(lpd_b),
    .o_single_channel_mode(sgl), .o_serial_link_enable(link_en), .o_cal_enable(cal_en),
    .o_reference_divisor(divisor), .o_divisor_enable(div_en),
    .o_phase_align_on_link(al_link), .o_phase_align_arm(al_arm));

  always #5 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // strobe dropped one edge later, so back-to-back calls never collide
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [15:0] m,
                        input logic [15:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(what, exp, rdata & m);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_pins(input logic [1:0] a, input logic [1:0] b);
    @(posedge clk);
    pins_a <= a;
    pins_b <= b;
  endtask

  task automatic t_reset;
    chk("route_b", 16'h0001, 16'(rt_b));
    chk("route_a", 16'h0000, 16'(rt_a));
    chk("div_en", 16'h0000, 16'(div_en));
    chk("align_link", 16'h0001, 16'(al_link));
    chk("align_arm", 16'h0000, 16'(al_arm));
    chk("ctrl_out", 16'h0000, 16'({sgl, link_en, cal_en}));
    rd_chk("binding", 12'h216, 16'hFFFF, 16'h0002);
    rd_chk("divisor", 12'h217, 16'hFFFF, 16'h0000);
    rd_chk("align", 12'h219, 16'hFFFF, 16'h0002);
    rd_chk("select", 12'h215, 16'hFFFF, 16'h0000);
    rd_chk("mode", 12'h214, 16'hFFFF, 16'h0000);
  endtask

  task automatic t_reg_select;
    set_pins(2'h2, 2'h1);
    for (int n = 0; n < 4; n++) begin
      wr(12'h215, 16'(((3 - n) << 2) | n));
      settle(1);
      chk("preset_a", 16'(n), 16'(act_a));
      chk("preset_b", 16'(3 - n), 16'(act_b));
    end
  endtask

  task automatic t_pin_modes;
    logic [1:0] ea [3] = '{2'h1, 2'h1, 2'h3};
    logic [1:0] eb [3] = '{2'h0, 2'h1, 2'h2};
    set_pins(2'h1, 2'h0);
    wr(12'h215, 16'h000B);
    for (int m = 1; m < 4; m++) begin
      wr(12'h214, 16'(m));
      settle(6);
      chk("mode_preset_a", 16'(ea[m-1]), 16'(act_a));
      chk("mode_preset_b", 16'(eb[m-1]), 16'(act_b));
    end
  endtask

  // binding stays at its default while single mode is on
  task automatic t_single;
    wr(12'h214, 16'h0000);
    wr(12'h200, 16'h0001);
    wr(12'h215, 16'h0006);
    settle(1);
    chk("single_a", 16'h0002, 16'(act_a));
    chk("single_b", 16'h0002, 16'(act_b));
    wr(12'h214, 16'h0001);
    settle(6);
    chk("single_pins_a", 16'h0001, 16'(act_a));
    chk("single_pins_b", 16'h0001, 16'(act_b));
    wr(12'h200, 16'h0000);
    wr(12'h214, 16'h0000);
  endtask

  task automatic t_binding;
    logic ea;
    logic eb;
    for (int b = 0; b < 4; b++) begin
      for (int p = 0; p < 4; p++) begin
        wr(12'h216, 16'(b));
        wr(12'h200, 16'(p << 3));
        settle(1);
        ea = b[0] ? p[1] : p[0];
        eb = b[1] ? p[1] : p[0];
        chk("route_a", 16'(b[0]), 16'(rt_a));
        chk("route_b", 16'(b[1]), 16'(rt_b));
        chk("pd_dig_link", 16'({ea, eb, ea, eb}), 16'({dpd_a, dpd_b, lpd_a, lpd_b}));
        chk("conv_pd", 16'({p[1], p[0]}), 16'({cpd_b, cpd_a}));
      end
    end
    wr(12'h200, 16'h0000);
    wr(12'h216, 16'h0002);
  endtask

  task automatic t_divisor;
    logic [15:0] v [4] = '{16'hFFFF, 16'h2000, 16'h2001, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      wr(12'h217, v[i]);
      settle(1);
      chk("divisor_out", v[i], divisor);
      chk("div_en", 16'(v[i] != 16'h0000), 16'(div_en));
      rd_chk("div_high", 12'h201, 16'h0080, (v[i] > 16'h2000) ? 16'h0080 : 16'h0000);
      rd_chk("divisor_rd", 12'h217, 16'hFFFF, v[i]);
    end
  endtask

  task automatic t_unmapped;
    wr(12'h218, 16'hFFFF);
    rd_chk("unmapped", 12'h218, 16'hFFFF, 16'h0000);
    rd_chk("binding_kept", 12'h216, 16'hFFFF, 16'h0002);
  endtask

  // same-value binding write with link on: no rebind, but the sticky flag must rise
  task automatic t_ctrl_flags;
    wr(12'h200, 16'h0006);
    settle(1);
    chk("ctrl_out", 16'h0003, 16'({sgl, link_en, cal_en}));
    wr(12'h216, 16'h0002);
    rd_chk("unsafe_set", 12'h201, 16'h0040, 16'h0040);
    wr(12'h201, 16'h0040);
    rd_chk("unsafe_clr", 12'h201, 16'h0040, 16'h0000);
    wr(12'h200, 16'h0001);
    settle(1);
    chk("ctrl_out", 16'h0004, 16'({sgl, link_en, cal_en}));
    wr(12'h200, 16'h0000);
  endtask

  // arm pulses once for 0 then 1, never for 1 over 1
  task automatic t_phase_align;
    wr(12'h219, 16'h0000);
    #1;
    chk("arm_low", 16'h0000, 16'(al_arm));
    settle(1);
    chk("align_link", 16'h0000, 16'(al_link));
    wr(12'h219, 16'h0001);
    #1;
    chk("arm_pulse", 16'h0001, 16'(al_arm));
    settle(1);
    chk("arm_end", 16'h0000, 16'(al_arm));
    wr(12'h219, 16'h0001);
    #1;
    chk("arm_again", 16'h0000, 16'(al_arm));
    rd_chk("align_rd", 12'h219, 16'hFFFF, 16'h0001);
  endtask

  // second reset in mid-run must bring binding, divisor, alignment, select, mode and the mode/link/cal outputs back
  task automatic t_mid_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    settle(1);
    t_reset;
  endtask

  task automatic conclude;
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    settle(1);
    t_reset;
    t_reg_select;
    t_pin_modes;
    t_single;
    t_binding;
    t_divisor;
    t_unmapped;
    t_ctrl_flags;
    t_phase_align;
    t_mid_reset;
    conclude;
  end

  // whole run is under a thousand cycles
  initial begin
    #50000;
    fails++;
    conclude;
  end
endmodule
